//--- core/qst_status_top.sv
// questionable status hierarchy with wishbone register access
// How it works
// [RULE1] preset clears all nine enable masks
// [RULE2] event read returns bits then clears
// [RULE3] enabled event bit sets questionable summary bit
// [RULE4] event enable mask writable and readable
// [RULE5] instrument event read returns then clears
// [RULE6] instrument enable mask writable and readable
// [RULE7] mask text decoded as #b, #h, decimal
// [RULE8] enabled instrument event sets rollup bit
// [RULE9] enabled summary event sets instrument bit 1
//
// Register access over Wishbone and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module qst_status_top (
    input  wire logic                        CORE_CLK_I,
    input  wire logic                        RST_N_I,
    input  wire logic                        WB_CYC_I,
    input  wire logic                        WB_STB_I,
    input  wire logic                        WB_WE_I,
    input  wire logic [qst_pkg::QST_AW-1:0]  WB_ADR_I,
    input  wire logic [3:0]                  WB_SEL_I,
    input  wire logic [qst_pkg::QST_DW-1:0]  WB_DAT_I,
    output logic      [qst_pkg::QST_DW-1:0]  WB_DAT_O,
    output logic                             WB_ACK_O,
    input  wire logic [qst_pkg::QST_RW-1:0]  QUES_COND_I,
    input  wire logic [qst_pkg::QST_RW-1:0]  QINST_COND_I,
    input  wire logic [qst_pkg::QST_RW-1:0]  QISUM_COND_I,
    output logic                             QUESTIONABLE_SUMMARY_BIT_O,
    output logic                             IRQ_O
);
    import qst_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic                        ack;
        logic [QST_DW-1:0]           dat;
        logic [QST_NMASK-1:0][15:0]  mask;
        logic [2:0][15:0]            s1;
        logic [2:0][15:0]            s2;
        logic [2:0][15:0]            s3;
        logic                        chr_vld;
        logic [7:0]                  chr;
        logic                        pclr;
        logic                        qsb;
        logic                        perr_d;
        logic [1:0]                  irq_st;
        logic [1:0]                  irq_msk;
        logic                        irq;
    } qst_top_s;

    qst_top_s st;
    qst_top_s next_st;

    logic        acc;
    logic        wr;
    logic        rd;
    logic [15:0] ques_ev;
    logic [15:0] qinst_ev;
    logic [15:0] qisum_ev;
    logic        ques_sum;
    logic        qinst_sum;
    logic        qisum_sum;
    logic [15:0] ques_set;
    logic [15:0] qinst_set;
    logic [15:0] qisum_set;
    logic        clr_ques;
    logic        clr_qinst;
    logic        clr_qisum;
    logic [15:0] pval;
    logic        perr;
    logic [3:0]  tgt;

    function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
        logic [15:0] r;
        r = old;
        if (sel[0])
            r[7:0] = d[7:0];
        if (sel[1])
            r[15:8] = d[15:8];
        return r;
    endfunction

    // ------------------------------------------------------------------
    // bus decode and event roll-up
    // ------------------------------------------------------------------
    assign acc       = WB_CYC_I && WB_STB_I && !st.ack;
    assign wr        = acc && WB_WE_I;
    assign rd        = acc && !WB_WE_I;
    assign clr_ques  = rd && WB_ADR_I == QST_QEV_OFS;   // RULE2
    assign clr_qinst = rd && WB_ADR_I == QST_QIEV_OFS;  // RULE5
    assign clr_qisum = rd && WB_ADR_I == QST_QSEV_OFS;
    assign tgt       = WB_DAT_I[QST_CTRL_TGT_LO +: 4];

    always_comb
    begin
        qisum_set = st.s2[2] & ~st.s3[2];
        qinst_set = st.s2[1] & ~st.s3[1];
        qinst_set[QST_QISUM_BIT] = qinst_set[QST_QISUM_BIT] | qisum_sum;     // RULE9
        ques_set  = st.s2[0] & ~st.s3[0];
        ques_set[QST_ROLLUP_BIT] = ques_set[QST_ROLLUP_BIT] | qinst_sum;     // RULE8
    end

    qst_event_reg #(.W(QST_RW)) u_qisum (
        .clk_i     (CORE_CLK_I),
        .rst_n_i   (RST_N_I),
        .set_i     (qisum_set),
        .clr_i     (clr_qisum),
        .mask_i    (st.mask[QST_M_QSEN]),
        .event_o   (qisum_ev),
        .summary_o (qisum_sum)
    );

    qst_event_reg #(.W(QST_RW)) u_qinst (
        .clk_i     (CORE_CLK_I),
        .rst_n_i   (RST_N_I),
        .set_i     (qinst_set),
        .clr_i     (clr_qinst),
        .mask_i    (st.mask[QST_M_QIEN]),
        .event_o   (qinst_ev),
        .summary_o (qinst_sum)
    );

    qst_event_reg #(.W(QST_RW)) u_ques (
        .clk_i     (CORE_CLK_I),
        .rst_n_i   (RST_N_I),
        .set_i     (ques_set),
        .clr_i     (clr_ques),
        .mask_i    (st.mask[QST_M_QEN]),
        .event_o   (ques_ev),
        .summary_o (ques_sum)
    );

    qst_value_parser u_parse (
        .clk_i     (CORE_CLK_I),
        .rst_n_i   (RST_N_I),
        .clr_i     (st.pclr),
        .chr_vld_i (st.chr_vld),
        .chr_i     (st.chr),
        .value_o   (pval),
        .err_o     (perr)
    );

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_st         = st;
        next_st.s1      = {QISUM_COND_I, QINST_COND_I, QUES_COND_I};
        next_st.s2      = st.s1;
        next_st.s3      = st.s2;
        next_st.ack     = acc;
        next_st.chr_vld = 1'b0;
        next_st.pclr    = 1'b0;
        next_st.qsb     = ques_sum;                                         // RULE3
        next_st.perr_d  = perr;
        if (rd)
        begin
            case (WB_ADR_I)
                QST_PARSE_OFS:   next_st.dat = {15'h0000, perr, pval};
                QST_QEV_OFS:     next_st.dat = {16'h0000, ques_ev};         // RULE2
                QST_QEN_OFS:     next_st.dat = {16'h0000, st.mask[QST_M_QEN]};  // RULE4
                QST_QIEV_OFS:    next_st.dat = {16'h0000, qinst_ev};        // RULE5
                QST_QIEN_OFS:    next_st.dat = {16'h0000, st.mask[QST_M_QIEN]}; // RULE6
                QST_QSEV_OFS:    next_st.dat = {16'h0000, qisum_ev};
                QST_QSEN_OFS:    next_st.dat = {16'h0000, st.mask[QST_M_QSEN]};
                QST_OEN_OFS:     next_st.dat = {16'h0000, st.mask[QST_M_OEN]};
                QST_OIEN_OFS:    next_st.dat = {16'h0000, st.mask[QST_M_OIEN]};
                QST_OSEN_OFS:    next_st.dat = {16'h0000, st.mask[QST_M_OSEN]};
                QST_MEN_OFS:     next_st.dat = {16'h0000, st.mask[QST_M_MEN]};
                QST_MIEN_OFS:    next_st.dat = {16'h0000, st.mask[QST_M_MIEN]};
                QST_MSEN_OFS:    next_st.dat = {16'h0000, st.mask[QST_M_MSEN]};
                QST_STAT_OFS:    next_st.dat = {31'h00000000, st.qsb};
                QST_IRQ_ST_OFS:  next_st.dat = {30'h00000000, st.irq_st};
                QST_IRQ_MSK_OFS: next_st.dat = {30'h00000000, st.irq_msk};
                default:         next_st.dat = 32'h00000000;
            endcase
        end
        if (wr)
        begin
            case (WB_ADR_I)
                QST_CTRL_OFS:
                    if (WB_SEL_I[0])
                    begin
                        next_st.pclr = WB_DAT_I[QST_CTRL_PCLR];
                        if (WB_DAT_I[QST_CTRL_PRESET])
                            next_st.mask = {QST_NMASK{QST_MASK_RST}};       // RULE1
                        else if (WB_DAT_I[QST_CTRL_COMMIT] && tgt < 4'(QST_NMASK))
                            next_st.mask[tgt] = pval;                       // RULE7
                    end
                QST_CHAR_OFS:
                    if (WB_SEL_I[0])
                    begin
                        next_st.chr_vld = 1'b1;                             // RULE7
                        next_st.chr     = WB_DAT_I[7:0];
                    end
                QST_QEN_OFS:  next_st.mask[QST_M_QEN]  = lane16(st.mask[QST_M_QEN], WB_DAT_I, WB_SEL_I);  // RULE4
                QST_QIEN_OFS: next_st.mask[QST_M_QIEN] = lane16(st.mask[QST_M_QIEN], WB_DAT_I, WB_SEL_I); // RULE6
                QST_QSEN_OFS: next_st.mask[QST_M_QSEN] = lane16(st.mask[QST_M_QSEN], WB_DAT_I, WB_SEL_I);
                QST_OEN_OFS:  next_st.mask[QST_M_OEN]  = lane16(st.mask[QST_M_OEN], WB_DAT_I, WB_SEL_I);
                QST_OIEN_OFS: next_st.mask[QST_M_OIEN] = lane16(st.mask[QST_M_OIEN], WB_DAT_I, WB_SEL_I);
                QST_OSEN_OFS: next_st.mask[QST_M_OSEN] = lane16(st.mask[QST_M_OSEN], WB_DAT_I, WB_SEL_I);
                QST_MEN_OFS:  next_st.mask[QST_M_MEN]  = lane16(st.mask[QST_M_MEN], WB_DAT_I, WB_SEL_I);
                QST_MIEN_OFS: next_st.mask[QST_M_MIEN] = lane16(st.mask[QST_M_MIEN], WB_DAT_I, WB_SEL_I);
                QST_MSEN_OFS: next_st.mask[QST_M_MSEN] = lane16(st.mask[QST_M_MSEN], WB_DAT_I, WB_SEL_I);
                QST_IRQ_ST_OFS:
                    if (WB_SEL_I[0])
                        next_st.irq_st = st.irq_st & ~WB_DAT_I[1:0];
                QST_IRQ_MSK_OFS:
                    if (WB_SEL_I[0])
                        next_st.irq_msk = WB_DAT_I[1:0];
                default: ;
            endcase
        end
        // set after clear so a new event survives a write-one-clear
        if (ques_sum && !st.qsb)
            next_st.irq_st[QST_IRQ_QSB] = 1'b1;
        if (perr && !st.perr_d)
            next_st.irq_st[QST_IRQ_PERR] = 1'b1;
        next_st.irq = |(next_st.irq_st & next_st.irq_msk);
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            st <= '0;
        else
            st <= next_st;
    end

    assign WB_ACK_O                   = st.ack;
    assign WB_DAT_O                   = st.dat;
    assign QUESTIONABLE_SUMMARY_BIT_O = st.qsb;
    assign IRQ_O                      = st.irq;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);

    logic [15:0] qen;
    logic [15:0] qien;
    assign qen  = st.mask[QST_M_QEN];
    assign qien = st.mask[QST_M_QIEN];

    sequence s_preset_wr;
        wr && WB_ADR_I == QST_CTRL_OFS && WB_SEL_I[0] && WB_DAT_I[QST_CTRL_PRESET];
    endsequence
    sequence s_qen_wr;
        wr && WB_ADR_I == QST_QEN_OFS && WB_SEL_I[1:0] == 2'b11;
    endsequence

    a_preset_clears_masks: assert property ( // RULE1
        s_preset_wr |=> st.mask == '0)
        else $error("preset left an enable mask set");
    a_ques_read_clear: assert property ( // RULE2
        clr_ques |=> WB_ACK_O && WB_DAT_O[15:0] == $past(ques_ev) && (ques_ev & ~$past(ques_set)) == 16'h0000)
        else $error("event read wrong value or not cleared");
    a_summary_bit_follows: assert property ( // RULE3
        ques_sum |=> QUESTIONABLE_SUMMARY_BIT_O)
        else $error("summary bit missed an enabled event");
    a_qen_write_read: assert property ( // RULE4
        s_qen_wr ##3 (rd && WB_ADR_I == QST_QEN_OFS) |=> WB_DAT_O[15:0] == $past(WB_DAT_I[15:0], 4))
        else $error("enable mask read back differs");
    a_qen_stores_data: assert property ( // RULE4
        s_qen_wr |=> qen == $past(WB_DAT_I[15:0]))
        else $error("enable mask write not stored");
    a_qinst_read_clear: assert property ( // RULE5
        clr_qinst |=> WB_DAT_O[15:0] == $past(qinst_ev) && (qinst_ev & ~$past(qinst_set)) == 16'h0000)
        else $error("instrument event read wrong or not cleared");
    a_qien_readback: assert property ( // RULE6
        (rd && WB_ADR_I == QST_QIEN_OFS) |=> WB_DAT_O[15:0] == $past(qien))
        else $error("instrument mask read back differs");
    a_commit_parsed: assert property ( // RULE7
        (wr && WB_ADR_I == QST_CTRL_OFS && WB_SEL_I[0] && !WB_DAT_I[QST_CTRL_PRESET]
         && WB_DAT_I[QST_CTRL_COMMIT] && tgt == QST_M_QEN) |=> qen == $past(pval))
        else $error("decoded value not committed");
    a_rollup_sets_bit: assert property ( // RULE8
        qinst_sum |=> ques_ev[QST_ROLLUP_BIT])
        else $error("instrument rollup bit not set");
    a_summary_sets_bit1: assert property ( // RULE9
        qisum_sum |=> qinst_ev[QST_QISUM_BIT])
        else $error("instrument bit 1 not set");

    // one acknowledge per taken access
    sequence s_acc_taken;
        acc;
    endsequence

    a_ack_one_pulse: assert property (
        s_acc_taken |=> WB_ACK_O ##1 !WB_ACK_O)
        else $error("acknowledge not a single pulse");
    a_summary_bit_drops: assert property ( // RULE3
        !ques_sum |=> !QUESTIONABLE_SUMMARY_BIT_O)
        else $error("summary bit set with no enabled event");
    a_irq_level: assert property (
        IRQ_O == |(st.irq_st & st.irq_msk))
        else $error("interrupt level disagrees with status");
    a_perr_irq_set: assert property (
        (perr && !st.perr_d) |=> st.irq_st[QST_IRQ_PERR])
        else $error("parser error did not raise its status bit");
endmodule
`default_nettype wire

//--- core/qst_pkg.sv
// constants, offsets and types shared by the questionable status block
package qst_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int unsigned QST_AW    = 8;
    localparam int unsigned QST_DW    = 32;
    localparam int unsigned QST_RW    = 16;
    localparam int unsigned QST_NMASK = 9;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] QST_CTRL_OFS      = 8'h00;
    localparam logic [7:0] QST_CHAR_OFS      = 8'h04;
    localparam logic [7:0] QST_PARSE_OFS     = 8'h08;
    localparam logic [7:0] QST_QEV_OFS       = 8'h0c;
    localparam logic [7:0] QST_QEN_OFS       = 8'h10;
    localparam logic [7:0] QST_QIEV_OFS      = 8'h14;
    localparam logic [7:0] QST_QIEN_OFS      = 8'h18;
    localparam logic [7:0] QST_QSEV_OFS      = 8'h1c;
    localparam logic [7:0] QST_QSEN_OFS      = 8'h20;
    localparam logic [7:0] QST_OEN_OFS       = 8'h24;
    localparam logic [7:0] QST_OIEN_OFS      = 8'h28;
    localparam logic [7:0] QST_OSEN_OFS      = 8'h2c;
    localparam logic [7:0] QST_MEN_OFS       = 8'h30;
    localparam logic [7:0] QST_MIEN_OFS      = 8'h34;
    localparam logic [7:0] QST_MSEN_OFS      = 8'h38;
    localparam logic [7:0] QST_STAT_OFS      = 8'h3c;
    localparam logic [7:0] QST_IRQ_ST_OFS    = 8'h40;
    localparam logic [7:0] QST_IRQ_MSK_OFS   = 8'h44;

    // ------------------------------------------------------------------
    // mask indices, bit positions, reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] QST_M_OEN  = 4'h0;
    localparam logic [3:0] QST_M_OIEN = 4'h1;
    localparam logic [3:0] QST_M_OSEN = 4'h2;
    localparam logic [3:0] QST_M_MEN  = 4'h3;
    localparam logic [3:0] QST_M_MIEN = 4'h4;
    localparam logic [3:0] QST_M_MSEN = 4'h5;
    localparam logic [3:0] QST_M_QEN  = 4'h6;
    localparam logic [3:0] QST_M_QIEN = 4'h7;
    localparam logic [3:0] QST_M_QSEN = 4'h8;

    localparam int unsigned QST_CTRL_PRESET  = 0;
    localparam int unsigned QST_CTRL_COMMIT  = 1;
    localparam int unsigned QST_CTRL_PCLR    = 2;
    localparam int unsigned QST_CTRL_TGT_LO  = 4;
    localparam int unsigned QST_ROLLUP_BIT   = 13;
    localparam int unsigned QST_QISUM_BIT    = 1;
    localparam int unsigned QST_PARSE_ERR    = 16;
    localparam int unsigned QST_IRQ_QSB      = 0;
    localparam int unsigned QST_IRQ_PERR     = 1;
    localparam logic [15:0] QST_MASK_RST     = 16'h0000;

    // ------------------------------------------------------------------
    // value parser
    // ------------------------------------------------------------------
    localparam logic [7:0] QST_CH_HASH = 8'h23;
    localparam logic [7:0] QST_CH_ZERO = 8'h30;
    localparam logic [7:0] QST_CH_NINE = 8'h39;
    localparam logic [7:0] QST_CH_UA   = 8'h41;
    localparam logic [7:0] QST_CH_UF   = 8'h46;
    localparam logic [7:0] QST_CH_LA   = 8'h61;
    localparam logic [7:0] QST_CH_LF   = 8'h66;
    localparam logic [7:0] QST_CH_UB   = 8'h42;
    localparam logic [7:0] QST_CH_LB   = 8'h62;
    localparam logic [7:0] QST_CH_UH   = 8'h48;
    localparam logic [7:0] QST_CH_LH   = 8'h68;

    typedef enum logic [2:0] {
        QST_PS_START  = 3'b000,
        QST_PS_PREFIX = 3'b001,
        QST_PS_BIN    = 3'b010,
        QST_PS_HEX    = 3'b011,
        QST_PS_DEC    = 3'b100
    } qst_parse_e;

endpackage

//--- core/qst_event_reg.sv
// sticky event register with read-clear and enabled summary
`timescale 1ns/1ps
`default_nettype none
module qst_event_reg #(
    parameter int unsigned W = 16
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic         clr_i,
    input  wire logic [W-1:0] mask_i,
    output logic      [W-1:0] event_o,
    output logic              summary_o
);
    typedef struct packed {
        logic [W-1:0] ev;
    } qst_evr_s;

    qst_evr_s st;
    qst_evr_s next_st;

    // set wins over a clear in the same cycle
    always_comb
    begin
        next_st    = st;
        next_st.ev = (st.ev & ~{W{clr_i}}) | set_i;
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign event_o   = st.ev;
    assign summary_o = |(st.ev & mask_i);
endmodule
`default_nettype wire

//--- core/qst_value_parser.sv
// ascii mask value decoder: #b binary, #h hex, plain decimal
`timescale 1ns/1ps
`default_nettype none
module qst_value_parser
    import qst_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        clr_i,
    input  wire logic        chr_vld_i,
    input  wire logic [7:0]  chr_i,
    output logic      [15:0] value_o,
    output logic             err_o
);
    typedef struct packed {
        qst_parse_e  ps;
        logic [15:0] value;
        logic        err;
    } qst_prs_s;

    qst_prs_s st;
    qst_prs_s next_st;
    logic     is_dec;
    logic     is_hex;
    logic [3:0] nib;
    logic [19:0] dec_acc;

    always_comb
    begin
        is_dec = (chr_i >= QST_CH_ZERO) && (chr_i <= QST_CH_NINE);
        is_hex = is_dec || ((chr_i >= QST_CH_UA) && (chr_i <= QST_CH_UF))
                        || ((chr_i >= QST_CH_LA) && (chr_i <= QST_CH_LF));
        nib    = is_dec ? chr_i[3:0] : 4'(chr_i[3:0] + 4'h9);
        dec_acc = {1'b0, st.value, 3'b000} + {3'b000, st.value, 1'b0} + {16'h0000, nib};
        next_st = st;
        if (clr_i)
        begin
            next_st = '0;
        end
        else if (chr_vld_i && !st.err)
        begin
            case (st.ps)
                QST_PS_START:
                    if (chr_i == QST_CH_HASH)
                        next_st.ps = QST_PS_PREFIX;
                    else if (is_dec)
                    begin
                        next_st.ps    = QST_PS_DEC;
                        next_st.value = {12'h000, nib};
                    end
                    else
                        next_st.err = 1'b1;
                QST_PS_PREFIX:
                    if (chr_i == QST_CH_UB || chr_i == QST_CH_LB)
                        next_st.ps = QST_PS_BIN;
                    else if (chr_i == QST_CH_UH || chr_i == QST_CH_LH)
                        next_st.ps = QST_PS_HEX;
                    else
                        next_st.err = 1'b1;
                QST_PS_BIN:
                    if (chr_i == QST_CH_ZERO || chr_i == 8'h31)
                        next_st.value = {st.value[14:0], chr_i[0]};
                    else
                        next_st.err = 1'b1;
                QST_PS_HEX:
                    if (is_hex)
                        next_st.value = {st.value[11:0], nib};
                    else
                        next_st.err = 1'b1;
                QST_PS_DEC:
                    if (is_dec)
                        next_st.value = dec_acc[15:0];
                    else
                        next_st.err = 1'b1;
                default:
                    next_st.err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign value_o = st.value;
    assign err_o   = st.err;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    logic [11:0] low12;
    logic [14:0] low15;
    assign low12 = st.value[11:0];
    assign low15 = st.value[14:0];

    a_hex_digit_shift: assert property ( // RULE7
        (!clr_i && chr_vld_i && !st.err && st.ps == QST_PS_HEX && is_hex)
        |=> value_o == {$past(low12), $past(nib)})
        else $error("hex digit not shifted in");
    a_bin_digit_shift: assert property ( // RULE7
        (!clr_i && chr_vld_i && !st.err && st.ps == QST_PS_BIN && chr_i == QST_CH_ZERO)
        |=> value_o == {$past(low15), 1'b0})
        else $error("binary digit not shifted in");
endmodule
`default_nettype wire

//--- tb/qst_host_model.sv
// host model: wishbone master that issues status commands and queries
`timescale 1ns/1ps
`default_nettype none
module qst_host_model
    import qst_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o,
    output logic             we_o,
    output logic [7:0]       adr_o,
    output logic [31:0]      dat_o,
    output logic             timeout_o
);
    initial
    begin
        cyc_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        dat_o = 32'h0;
        timeout_o = 1'b0;
    end

    // ------------------------------------------------------------------
    // single classic cycle, held until ack is seen at an edge
    // ------------------------------------------------------------------
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        we_o <= w;
        adr_o <= a;
        dat_o <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_i !== 1'b1 && n < 50);
        q = dat_i;
        if (n >= 50)
            timeout_o <= 1'b1;
        cyc_o <= 1'b0;
    endtask

    // mask value as text: clear parser, one char per write, let it settle
    task automatic send(input string s);
        logic [31:0] q;
        bus(1'b1, QST_CTRL_OFS, 32'h4, q);
        for (int k = 0; k < s.len(); k++)
            bus(1'b1, QST_CHAR_OFS, {24'h0, s[k]}, q);
        repeat (2) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

//--- tb/test_questionable_status_model.sv
// self-checking testbench for the questionable status block
`timescale 1ns/1ps
`default_nettype none
module test_questionable_status_model;
    import qst_pkg::*;

    logic        core_clk;
    logic        rst_n;
    logic        cyc, we, ack, irq, qsb, hto;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat;
    logic [15:0] ques_cond, qinst_cond, qisum_cond;
    int          mismatches, comparisons;
    logic [7:0]  mofs [9] = '{QST_OEN_OFS, QST_OIEN_OFS, QST_OSEN_OFS, QST_MEN_OFS, QST_MIEN_OFS,
                              QST_MSEN_OFS, QST_QEN_OFS, QST_QIEN_OFS, QST_QSEN_OFS};
    string       txt [3] = '{"#b0000000000001010", "#hA", "10"};

    qst_status_top qst_status_top_i (.CORE_CLK_I(core_clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(cyc),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .QUES_COND_I(ques_cond), .QINST_COND_I(qinst_cond), .QISUM_COND_I(qisum_cond),
        .QUESTIONABLE_SUMMARY_BIT_O(qsb), .IRQ_O(irq));

    qst_host_model qst_host_model_i (.clk_i(core_clk), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .we_o(we),
        .adr_o(adr), .dat_o(wdat), .timeout_o(hto));

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        qst_host_model_i.bus(1'b1, a, d, q);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        qst_host_model_i.bus(1'b0, a, 32'h0, d);
        chk($sformatf("reg %h", a), e, d);
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        #200000;
        mismatches++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // tests
    // ------------------------------------------------------------------
    initial
    begin
        rst_n = 1'b0;
        ques_cond = 16'h0;
        qinst_cond = 16'h0;
        qisum_cond = 16'h0;
        mismatches = 0;
        comparisons = 0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rc(QST_QEN_OFS, 32'h0);
        rc(QST_QIEN_OFS, 32'h0);
        wr(QST_QEN_OFS, 32'h2000);
        rc(QST_QEN_OFS, 32'h2000);
        wr(QST_QIEN_OFS, 32'h0002);
        rc(QST_QIEN_OFS, 32'h0002);
        rc(8'h80, 32'h0);
        $display("test access done");
        for (int i = 0; i < 9; i++)
        begin
            qst_host_model_i.send(txt[i % 3]);
            rc(QST_PARSE_OFS, 32'ha);
            wr(QST_CTRL_OFS, {24'h0, 4'(i), 4'h2});
            rc(mofs[i], 32'ha);
        end
        $display("test text decode done");
        wr(QST_QEN_OFS, 32'h2000);
        wr(QST_QIEN_OFS, 32'h0002);
        @(posedge core_clk);
        qisum_cond <= 16'h0002;
        ques_cond <= 16'h0008;
        qinst_cond <= 16'h0010;
        repeat (10) @(posedge core_clk);
        chk("summary bit", 32'h1, {31'h0, qsb});
        rc(QST_QEV_OFS, 32'h2008);
        rc(QST_QEV_OFS, 32'h2000);
        rc(QST_QIEV_OFS, 32'h0012);
        rc(QST_QIEV_OFS, 32'h0002);
        rc(QST_STAT_OFS, 32'h1);
        $display("test rollup done");
        rc(QST_IRQ_ST_OFS, 32'h1);
        wr(QST_IRQ_MSK_OFS, 32'h1);
        rc(QST_IRQ_MSK_OFS, 32'h1);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(QST_IRQ_ST_OFS, 32'h1);
        rc(QST_IRQ_ST_OFS, 32'h0);
        chk("irq off", 32'h0, {31'h0, irq});
        qst_host_model_i.send("#x");
        rc(QST_PARSE_OFS, 32'h10000);
        rc(QST_IRQ_ST_OFS, 32'h2);
        $display("test interrupt done");
        wr(QST_CTRL_OFS, 32'h83);
        for (int i = 0; i < 9; i++)
            rc(mofs[i], 32'h0);
        repeat (3) @(posedge core_clk);
        chk("summary cleared", 32'h0, {31'h0, qsb});
        chk("host timeout", 32'h0, {31'h0, hto});
        $display("test preset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
